/* shared/tmc_cnt_if.sv */
// interface: signals between the control logic and the counter unit
interface tmc_cnt_if;
  logic tick;
  logic wide;
  logic clr_match;
  logic [7:0] top_lo;
  logic load_lo;
  logic load_hi;
  logic [7:0] load_data;
  logic [15:0] cnt;
  logic at_max;

  modport ctrl (
    output tick,
    output wide,
    output clr_match,
    output top_lo,
    output load_lo,
    output load_hi,
    output load_data,
    input cnt,
    input at_max
  );

  modport counter (
    input tick,
    input wide,
    input clr_match,
    input top_lo,
    input load_lo,
    input load_hi,
    input load_data,
    output cnt,
    output at_max
  );
endinterface : tmc_cnt_if

/* shared/tmc_pkg.sv */
// package: register map, field positions, reset values and modes of the timer
package tmc_pkg;

  // register byte offsets on the avalon slave
  localparam logic [5:0] OFF_CNT_LO = 6'h00;
  localparam logic [5:0] OFF_CNT_HI = 6'h04;
  localparam logic [5:0] OFF_CMP_A = 6'h08;
  localparam logic [5:0] OFF_CMP_B = 6'h0C;
  localparam logic [5:0] OFF_CTRL_A = 6'h10;
  localparam logic [5:0] OFF_CTRL_B = 6'h14;
  localparam logic [5:0] OFF_FLAG = 6'h18;
  localparam logic [5:0] OFF_MASK = 6'h1C;

  // control_reg_a fields
  localparam int CA_CLR_MATCH = 0;
  localparam int CA_WIDTH = 1;
  localparam int CA_CAPTURE = 2;

  // flag and mask bit positions
  localparam int FL_OVF = 0;
  localparam int FL_CMP_A = 1;
  localparam int FL_CMP_B = 2;
  localparam int FL_CAP = 3;
  localparam int NFLAGS = 4;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_CTRL_A = 3'h0;
  localparam logic [2:0] RST_CS = 3'h0;
  localparam logic [3:0] RST_FLAGS = 4'h0;

  // count limits
  localparam logic [7:0] MAX8 = 8'hFF;
  localparam logic [15:0] MAX16 = 16'hFFFF;
  localparam logic [15:0] BOTTOM = 16'h0000;

  // clock source codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // prescaler tap masks: a tap fires when its low bits are all ones
  localparam int PSC_W = 10;
  localparam logic [9:0] TAP8 = 10'h007;
  localparam logic [9:0] TAP64 = 10'h03F;
  localparam logic [9:0] TAP256 = 10'h0FF;
  localparam logic [9:0] TAP1024 = 10'h3FF;

  typedef enum logic [2:0] {
    MD_NORMAL8,
    MD_CTC8,
    MD_WIDE16,
    MD_CAP8,
    MD_CAP16
  } tmc_mode_t;

endpackage : tmc_pkg

/* src/tmc_counter.sv */
// counter unit: up counter of 8 or 16 bits with load and clear on match
module tmc_counter
  import tmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  tmc_cnt_if.counter cif
);

  logic [15:0] cnt_q;

  // MAX depends on the width in use
  assign cif.at_max = cif.wide ? (cnt_q == MAX16) : (cnt_q[7:0] == MAX8);
  assign cif.cnt = cnt_q;

  // cpu load beats clear and count; high byte only counts in 16-bit
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cnt_q <= BOTTOM;
    end
    else if (cif.load_lo || cif.load_hi)
    begin
      if (cif.load_lo)
      begin
        cnt_q[7:0] <= cif.load_data;
      end
      if (cif.load_hi)
      begin
        cnt_q[15:8] <= cif.load_data;
      end
    end
    else if (cif.tick)
    begin
      if (cif.wide)
      begin
        cnt_q <= cnt_q + 16'h0001;
      end
      else if (cif.clr_match && (cnt_q[7:0] == cif.top_lo))
      begin
        cnt_q[7:0] <= BOTTOM[7:0];
      end
      else
      begin
        cnt_q[7:0] <= cnt_q[7:0] + 8'h01;
      end
    end
  end

endmodule : tmc_counter

/* src/tmc_top.sv */
// top: timer control, compare, capture, flags and avalon register slave
//
// What this block does
// - 16-bit mode adds high counter byte; compare a low, compare b high.
// - every request is a flag in timer_flag_reg, masked per bit.
// - BOTTOM is zero; MAX is 0xFF narrow, 0xFFFF wide.
// - TOP is fixed MAX or compare_value_a, by mode.
// - tick comes from clock_source_select; zero stops the counter.
// - count up one per tick, restart at BOTTOM after TOP.
// - cpu reads and writes counter anytime; write beats clear and count.
// - mode decoded from capture enable, width select, clear-on-match select.
// - normal 8-bit wraps 0xFF to 0x00 and sets overflow then.
// - overflow only set by counting; cleared when serviced.
// - 16-bit counts to 0xFFFF, wraps, sets overflow at zero.
// - new counter value may be written any time in normal modes.
// - clear-on-match clears counter when it equals compare_value_a.
// - clear-on-match sets compare_flag_a once each period at TOP.
// - compare a below count is missed until wrap through 0xFF.
// - clear-on-match sets overflow on MAX to zero rollover too.
// - capture copies counter into compare storage, sets capture flag same clock.
// - 16-bit capture uses compare b as high byte; 8-bit keeps it.
// - equal counter sets compare flag at next tick; wide sets only a; capture modes never set a.
// - a counter write suppresses compare matches at the following tick.
module tmc_top
  import tmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_count_pin,
  input wire logic capture_event,
  input wire logic [tmc_pkg::NFLAGS-1:0] irq_ack,
  output logic [tmc_pkg::NFLAGS-1:0] irq_req
);
  import tmc_pkg::*;

  tmc_cnt_if cif ();

  logic ack_q;
  logic [31:0] rdata_q;
  logic wr_go;
  logic wr_lane;
  logic [7:0] wbyte;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  logic [2:0] ctrl_a_q;
  logic [2:0] cs_q;
  logic [NFLAGS-1:0] flags_q;
  logic [NFLAGS-1:0] mask_q;
  logic [NFLAGS-1:0] flag_set;
  logic [NFLAGS-1:0] flag_clr;
  logic block_q;
  logic [PSC_W-1:0] psc_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic pin_lvl_q;
  logic ext_rise;
  logic ext_fall;
  logic tick;
  logic cnt_wr;
  logic match_a;
  logic match_b;
  logic cap_go;
  tmc_mode_t mode;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------

  // capture enable, width select, clear-on-match select
  always_comb
  begin
    if (ctrl_a_q[CA_CAPTURE] && ctrl_a_q[CA_WIDTH])
    begin
      mode = MD_CAP16;
    end
    else if (ctrl_a_q[CA_CAPTURE])
    begin
      mode = MD_CAP8;
    end
    else if (ctrl_a_q[CA_WIDTH])
    begin
      mode = MD_WIDE16;
    end
    else if (ctrl_a_q[CA_CLR_MATCH])
    begin
      mode = MD_CTC8;
    end
    else
    begin
      mode = MD_NORMAL8;
    end
  end

  // ------------------------------------------------------------
  // avalon slave
  // ------------------------------------------------------------

  // one wait cycle per request, then release
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_go = avs_write && ack_q;
  assign wr_lane = wr_go && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign avs_readdata = rdata_q;

  // acknowledge toggles in the cycle after a request appears
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // read data registered during the wait cycle, unmapped reads zero
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (avs_read && !ack_q)
    begin
      if (avs_address == OFF_CNT_LO)
      begin
        rdata_q <= {24'h000000, cif.cnt[7:0]};
      end
      else if (avs_address == OFF_CNT_HI)
      begin
        rdata_q <= {24'h000000, cif.cnt[15:8]};
      end
      else if (avs_address == OFF_CMP_A)
      begin
        rdata_q <= {24'h000000, cmp_a_q};
      end
      else if (avs_address == OFF_CMP_B)
      begin
        rdata_q <= {24'h000000, cmp_b_q};
      end
      else if (avs_address == OFF_CTRL_A)
      begin
        rdata_q <= {29'h0000000, ctrl_a_q};
      end
      else if (avs_address == OFF_CTRL_B)
      begin
        rdata_q <= {29'h0000000, cs_q};
      end
      else if (avs_address == OFF_FLAG)
      begin
        rdata_q <= {28'h0000000, flags_q};
      end
      else if (avs_address == OFF_MASK)
      begin
        rdata_q <= {28'h0000000, mask_q};
      end
      else
      begin
        rdata_q <= 32'h00000000;
      end
    end
  end

  // control and mask registers
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrl_a_q <= RST_CTRL_A;
      cs_q <= RST_CS;
      mask_q <= RST_FLAGS;
    end
    else if (wr_lane)
    begin
      if (avs_address == OFF_CTRL_A)
      begin
        ctrl_a_q <= wbyte[2:0];
      end
      else if (avs_address == OFF_CTRL_B)
      begin
        cs_q <= wbyte[2:0];
      end
      else if (avs_address == OFF_MASK)
      begin
        mask_q <= wbyte[NFLAGS-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // timer tick
  // ------------------------------------------------------------

  // free running prescaler
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      psc_q <= '0;
    end
    else
    begin
      psc_q <= psc_q + 10'h001;
    end
  end

  // external pin: three stages, level moves when stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      pin_lvl_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= external_count_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q)
      begin
        pin_lvl_q <= pin_s3_q;
      end
    end
  end

  assign ext_rise = (pin_s2_q == pin_s3_q) && pin_s3_q && !pin_lvl_q;
  assign ext_fall = (pin_s2_q == pin_s3_q) && !pin_s3_q && pin_lvl_q;

  // clock select picks the tick source; code zero stops the timer
  always_comb
  begin
    case (cs_q)
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (psc_q & TAP8) == TAP8;
      CS_DIV64: tick = (psc_q & TAP64) == TAP64;
      CS_DIV256: tick = (psc_q & TAP256) == TAP256;
      CS_DIV1024: tick = (psc_q & TAP1024) == TAP1024;
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
      default: tick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // counter unit hookup
  // ------------------------------------------------------------

  assign cnt_wr = wr_lane && ((avs_address == OFF_CNT_LO) || (avs_address == OFF_CNT_HI));
  assign cif.tick = tick;
  assign cif.wide = (mode == MD_WIDE16) || (mode == MD_CAP16);
  assign cif.clr_match = (mode == MD_CTC8);
  assign cif.top_lo = cmp_a_q;
  assign cif.load_lo = wr_lane && (avs_address == OFF_CNT_LO);
  assign cif.load_hi = wr_lane && (avs_address == OFF_CNT_HI);
  assign cif.load_data = wbyte;

  tmc_counter u_counter (
    .sys_clk(sys_clk),
    .srst(srst),
    .cif(cif.counter)
  );

  // ------------------------------------------------------------
  // compare and capture
  // ------------------------------------------------------------

  // wide mode compares against the merged 16-bit value
  assign match_a = cif.wide ? (cif.cnt == {cmp_b_q, cmp_a_q}) : (cif.cnt[7:0] == cmp_a_q);
  assign match_b = cif.cnt[7:0] == cmp_b_q;
  assign cap_go = capture_event && ((mode == MD_CAP8) || (mode == MD_CAP16));

  // compare storage; a capture overrides a bus write in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cmp_a_q <= RST_BYTE;
      cmp_b_q <= RST_BYTE;
    end
    else
    begin
      if (cap_go)
      begin
        cmp_a_q <= cif.cnt[7:0];
      end
      else if (wr_lane && (avs_address == OFF_CMP_A))
      begin
        cmp_a_q <= wbyte;
      end
      if (cap_go && (mode == MD_CAP16))
      begin
        cmp_b_q <= cif.cnt[15:8];
      end
      else if (wr_lane && (avs_address == OFF_CMP_B))
      begin
        cmp_b_q <= wbyte;
      end
    end
  end

  // a counter write blocks matches until the next tick has passed
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      block_q <= 1'b0;
    end
    else if (cnt_wr)
    begin
      block_q <= 1'b1;
    end
    else if (tick)
    begin
      block_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt flags
  // ------------------------------------------------------------

  // flag set terms; a counter write in the same cycle cancels the count
  always_comb
  begin
    flag_set = '0;
    flag_set[FL_OVF] = tick && cif.at_max && !cnt_wr;
    flag_set[FL_CMP_A] = tick && match_a && !block_q && !cnt_wr
      && (mode != MD_CAP8) && (mode != MD_CAP16);
    flag_set[FL_CMP_B] = tick && match_b && !block_q && !cnt_wr
      && !cif.wide;
    flag_set[FL_CAP] = cap_go;
  end

  // serviced requests and write-one from software clear flags
  always_comb
  begin
    flag_clr = irq_ack;
    if (wr_lane && (avs_address == OFF_FLAG))
    begin
      flag_clr = flag_clr | wbyte[NFLAGS-1:0];
    end
  end

  // sticky flags, a set wins over a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      flags_q <= RST_FLAGS;
    end
    else
    begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // each request gated by its own mask bit
  assign irq_req = flags_q & mask_q;

endmodule : tmc_top

/* tb/tb_tmc_top.sv */
// testbench: drives the timer over avalon and its pins, checks readback
module tb_tmc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tmc_pkg::*;

  logic sys_clk;
  logic srst;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic external_count_pin;
  logic capture_event;
  logic [NFLAGS-1:0] irq_ack;
  logic [NFLAGS-1:0] irq_req;
  int err_total;
  int checked;
  int cyc;

  tmc_top uut (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_count_pin(external_count_pin), .capture_event(capture_event),
    .irq_ack(irq_ack), .irq_req(irq_req)
  );

  // -----
  // tasks
  // -----
  task automatic results;
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  // one transfer: request held until waitrequest is sampled low; only the bench timeout ends a hang
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rd

  // rising pin edges, each one timer tick a few cycles later
  task automatic ticks(input int k);
    repeat (k)
    begin
      @(posedge sys_clk);
      external_count_pin <= 1'b1;
      repeat (6) @(posedge sys_clk);
      external_count_pin <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
  endtask : ticks

  // one-cycle capture or acknowledge pulse, then let it land
  task automatic strobe(input logic cap, input logic [3:0] ack);
    @(posedge sys_clk);
    capture_event <= cap;
    irq_ack <= ack;
    @(posedge sys_clk);
    capture_event <= 1'b0;
    irq_ack <= 4'h0;
    @(posedge sys_clk);
  endtask : strobe

  // ---------
  // scenarios
  // ---------
  task automatic t_reset;
    for (int i = 0; i < 8; i++)
      rd(6'(4 * i), 8'h00);
    rd(6'h20, 8'h00);
  endtask : t_reset

  task automatic t_normal;
    wr(OFF_CNT_LO, 8'hFE);
    wr(OFF_MASK, 8'h01);
    ticks(2);
    rd(OFF_CNT_LO, 8'hFE);
    wr(OFF_CTRL_B, {5'h00, CS_EXT_RISE});
    ticks(1);
    rd(OFF_CNT_LO, 8'hFF);
    rd(OFF_FLAG, 8'h00);
    ticks(1);
    rd(OFF_CNT_LO, 8'h00);
    rd(OFF_FLAG, 8'h01);
    chk({4'h0, irq_req}, 8'h01);
    strobe(1'b0, 4'h1);
    chk({4'h0, irq_req}, 8'h00);
    wr(OFF_CMP_B, 8'h02);
    ticks(2);
    rd(OFF_FLAG, 8'h02);
    ticks(1);
    rd(OFF_FLAG, 8'h06);
    wr(OFF_FLAG, 8'h0F);
    wr(OFF_CMP_A, 8'h10);
    wr(OFF_CNT_LO, 8'h10);
    ticks(1);
    rd(OFF_CNT_LO, 8'h11);
    rd(OFF_FLAG, 8'h00);
  endtask : t_normal

  task automatic t_ctc;
    wr(OFF_FLAG, 8'h0F);
    wr(OFF_CTRL_A, 8'h01);
    wr(OFF_CMP_A, 8'h03);
    wr(OFF_CNT_LO, 8'h00);
    ticks(3);
    rd(OFF_CNT_LO, 8'h03);
    ticks(1);
    rd(OFF_CNT_LO, 8'h00);
    rd(OFF_FLAG, 8'h06);
    wr(OFF_FLAG, 8'h0F);
    wr(OFF_CNT_LO, 8'hFD);
    wr(OFF_CMP_A, 8'h01);
    ticks(3);
    rd(OFF_CNT_LO, 8'h00);
    rd(OFF_FLAG, 8'h01);
    ticks(2);
    rd(OFF_CNT_LO, 8'h00);
    rd(OFF_FLAG, 8'h03);
  endtask : t_ctc

  task automatic t_wide;
    wr(OFF_FLAG, 8'h0F);
    wr(OFF_CTRL_A, 8'h02);
    wr(OFF_CMP_A, 8'hFE);
    wr(OFF_CMP_B, 8'hFF);
    wr(OFF_CNT_HI, 8'hFF);
    wr(OFF_CNT_LO, 8'hFD);
    ticks(2);
    rd(OFF_FLAG, 8'h02);
    rd(OFF_CNT_LO, 8'hFF);
    ticks(1);
    rd(OFF_CNT_HI, 8'h00);
    rd(OFF_CNT_LO, 8'h00);
    rd(OFF_FLAG, 8'h03);
    wr(OFF_CTRL_B, {5'h00, CS_DIV1});
    wr(OFF_CTRL_B, {5'h00, CS_STOP});
    rd(OFF_CNT_LO, 8'h03);
  endtask : t_wide

  task automatic t_capture;
    wr(OFF_CTRL_B, 8'h00);
    wr(OFF_FLAG, 8'h0F);
    wr(OFF_MASK, 8'h0F);
    wr(OFF_CTRL_A, 8'h06);
    wr(OFF_CNT_HI, 8'h12);
    wr(OFF_CNT_LO, 8'h34);
    strobe(1'b1, 4'h0);
    rd(OFF_CMP_A, 8'h34);
    rd(OFF_CMP_B, 8'h12);
    chk({4'h0, irq_req}, 8'h08);
    strobe(1'b0, 4'h8);
    chk({4'h0, irq_req}, 8'h00);
    wr(OFF_CTRL_A, 8'h04);
    wr(OFF_CMP_B, 8'h55);
    wr(OFF_CNT_LO, 8'h77);
    strobe(1'b1, 4'h0);
    rd(OFF_CMP_A, 8'h77);
    rd(OFF_CMP_B, 8'h55);
    wr(OFF_FLAG, 8'h0F);
    @(posedge sys_clk);
    chk({4'h0, irq_req}, 8'h00);
    wr(OFF_MASK, 8'h00);
  endtask : t_capture

  // --------------
  // clock and main
  // --------------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // cuts a hung run short
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total++;
      results;
    end
  end

  // reset, then every scenario in turn
  initial
  begin
    err_total = 0;
    checked = 0;
    cyc = 0;
    srst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h1;
    external_count_pin = 1'b0;
    capture_event = 1'b0;
    irq_ack = 4'h0;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset;
    t_normal;
    t_ctc;
    t_wide;
    t_capture;
    results;
  end
endmodule : tb_tmc_top

bind tmc_top tmc_top_properties chk_u (
  .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .external_count_pin(external_count_pin), .capture_event(capture_event),
  .irq_ack(irq_ack), .irq_req(irq_req)
);

/* tb/tmc_top_properties.sv */
// checker: bus handshake, readback and interrupt request properties of the timer
module tmc_top_properties
  import tmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic external_count_pin,
  input wire logic capture_event,
  input wire logic [tmc_pkg::NFLAGS-1:0] irq_ack,
  input wire logic [tmc_pkg::NFLAGS-1:0] irq_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------
  // properties
  // ----------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  // a request in its wait state, and a write landing on this edge
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_wr_done;
    avs_write && !avs_waitrequest && avs_byteenable[0];
  endsequence

  chk_one_wait: assert property (s_req_wait |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  chk_first_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state");
  chk_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  chk_rdata_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_rdata_hold: assert property (avs_read && !avs_waitrequest |=> $stable(avs_readdata))
    else $error("read data moved");
  chk_reset_quiet: assert property ($fell(srst) |-> irq_req == 4'h0)
    else $error("request after reset");
  chk_mask_off: assert property (s_wr_done ##0 (avs_address == OFF_MASK
    && avs_writedata[3:0] == 4'h0) |=> irq_req == 4'h0)
    else $error("masked request still high");
  chk_cap_wone: assert property (s_wr_done ##0 (avs_address == OFF_FLAG
    && avs_writedata[FL_CAP] && !capture_event) |=> !irq_req[FL_CAP])
    else $error("capture flag not cleared by write");
  chk_cap_ack: assert property (irq_ack[FL_CAP] && !capture_event |=> !irq_req[FL_CAP])
    else $error("capture flag not cleared by ack");
  chk_cap_cause: assert property (!capture_event && !avs_write && !irq_req[FL_CAP] |=> !irq_req[FL_CAP])
    else $error("capture flag without event");
endmodule : tmc_top_properties
